// ==== smc_pkg.sv ====
// smc_pkg.sv: shared constants and types for the mode configuration block
package smc_pkg;

  // ==========================================================================
  // widths
  localparam int COL_W = 9;
  localparam int ADDR_W = 10;
  localparam int MODE_W = 10;
  localparam int EXT_W = 7;
  localparam logic [COL_W-1:0] COL_STEP = 9'h001;

  // ==========================================================================
  // base register field encodings
  localparam logic [2:0] SPAN_1 = 3'h0;
  localparam logic [2:0] SPAN_2 = 3'h1;
  localparam logic [2:0] SPAN_4 = 3'h2;
  localparam logic [2:0] SPAN_8 = 3'h3;
  localparam logic [2:0] SPAN_PAGE = 3'h7;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] OPMODE_NORMAL = 2'h0;

  // ==========================================================================
  // bank select codes that pick the target of a load
  localparam logic [1:0] BANK_BASE = 2'h0;
  localparam logic [1:0] BANK_EXT = 2'h2;

  // ==========================================================================
  // extended register field encodings
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_FULL = 3'h0;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_HALF = 3'h1;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_QUARTER = 3'h2;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_EIGHTH = 3'h5;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_SIXTEENTH = 3'h6;
  localparam logic [1:0] DS_FULL = 2'h0;
  localparam logic [1:0] DS_HALF = 2'h1;
  localparam logic [1:0] DS_QUARTER = 2'h2;
  localparam logic [1:0] DS_THREEQ = 2'h3;
  localparam logic [6:0] OHM_25 = 7'h19;
  localparam logic [6:0] OHM_37 = 7'h25;
  localparam logic [6:0] OHM_55 = 7'h37;
  localparam logic [6:0] OHM_80 = 7'h50;

  // ==========================================================================
  // refresh coverage codes
  localparam logic [3:0] BANKS_ALL = 4'hF;
  localparam logic [3:0] BANKS_LOW2 = 4'h3;
  localparam logic [3:0] BANKS_ZERO = 4'h1;
  localparam logic [1:0] ROWS_WHOLE = 2'h0;
  localparam logic [1:0] ROWS_HALF = 2'h1;
  localparam logic [1:0] ROWS_QUARTER = 2'h2;

  // ==========================================================================
  // reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h000;
  localparam logic [EXT_W-1:0] EXT_RESET = 7'h00;
  localparam logic [3:0] RATE_RESET = 4'h0;

  // ==========================================================================
  // types
  typedef struct packed {
    logic single_write_select;
    logic op_mode_high_bit;
    logic op_mode_low_bit;
    logic [2:0] latency;
    logic burst_order_select;
    logic [2:0] burst_span;
  } smc_mode_s;

  typedef struct packed {
    logic [1:0] output_drive_select;
    logic [1:0] temp_comp_refresh_bits;
    logic [2:0] partial_refresh_select;
  } smc_ext_s;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_sel_high;
    logic bank_sel_low;
    logic [ADDR_W-1:0] addr;
  } smc_cmd_s;

  typedef struct packed {
    logic valid;
    logic rd;
    logic [COL_W-1:0] col;
  } smc_beat_s;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIXED, SEQ_PAGE} smc_seq_e;

endpackage : smc_pkg

// ==== smc_burst_seq.sv ====
// smc_burst_seq.sv: column order generator for one burst
`timescale 1ns/10ps
module smc_burst_seq
  import smc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic rd_in,
  input wire logic [COL_W-1:0] start_col_in,
  input wire logic [2:0] span_in,
  input wire logic order_in,
  output smc_beat_s beat_out
);

  smc_seq_e state_q;
  logic [COL_W-1:0] base_q;
  logic [2:0] mask_q;
  logic [2:0] cnt_q;
  logic order_q;
  smc_beat_s beat_q;
  logic [2:0] start_mask;
  logic [2:0] cnt_nxt;
  logic [2:0] low_nxt;
  logic [COL_W-1:0] mask_w;

  // ==========================================================================
  // block size from the span code; reserved codes fall back to one location
  always_comb
  begin
    case (span_in)
      SPAN_2: start_mask = 3'h1;
      SPAN_4: start_mask = 3'h3;
      SPAN_8: start_mask = 3'h7;
      default: start_mask = 3'h0;
    endcase
  end

  assign cnt_nxt = cnt_q + 3'h1;
  assign low_nxt = order_q ? (base_q[2:0] ^ cnt_nxt) : (base_q[2:0] + cnt_nxt);
  assign mask_w = {{(COL_W-3){1'b0}}, mask_q};
  assign beat_out = beat_q;

  // ==========================================================================
  // state
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_q <= SEQ_IDLE;
    else if (start_in)
      state_q <= (span_in == SPAN_PAGE) ? SEQ_PAGE : SEQ_FIXED;
    else if (stop_in)
      state_q <= SEQ_IDLE;
    else if (state_q == SEQ_FIXED && cnt_q == mask_q)
      state_q <= SEQ_IDLE;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      base_q <= '0;
      mask_q <= 3'h0;
      order_q <= 1'b0;
      cnt_q <= 3'h0;
    end
    else if (start_in)
    begin
      base_q <= start_col_in;
      mask_q <= start_mask;
      order_q <= order_in;
      cnt_q <= 3'h0;
    end
    else if (state_q == SEQ_FIXED)
      cnt_q <= cnt_nxt;
  end

  // ==========================================================================
  // beat output; page mode ignores the order bit and wraps at the page end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      beat_q <= '0;
    else if (start_in)
    begin
      beat_q.valid <= 1'b1;
      beat_q.rd <= rd_in;
      beat_q.col <= start_col_in;
    end
    else if (stop_in)
      beat_q.valid <= 1'b0;
    else if (state_q == SEQ_PAGE)
      beat_q.col <= beat_q.col + COL_STEP;
    else if (state_q == SEQ_FIXED && cnt_q != mask_q)
      beat_q.col <= (base_q & ~mask_w) | ({{(COL_W-3){1'b0}}, low_nxt} & mask_w);
    else
      beat_q.valid <= 1'b0;
  end

  // ==========================================================================
  // checks
  chk_seq_restart: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    start_in |=> beat_q.valid && beat_q.col == $past(start_col_in))
    else $error("burst did not restart at the new column");

  chk_seq_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    stop_in && !start_in |=> !beat_q.valid)
    else $error("burst kept running after terminate");

  chk_block_stay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == SEQ_FIXED |-> (beat_q.col & ~mask_w) == (base_q & ~mask_w))
    else $error("burst left its aligned block");

  chk_seq_ilv: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == SEQ_FIXED && order_q |-> beat_q.col[2:0] == ((base_q[2:0] ^ cnt_q) & mask_q)
      + (base_q[2:0] & ~mask_q))
    else $error("interleaved column order wrong");

  chk_seq_inc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == SEQ_FIXED && !order_q && !start_in && !stop_in && cnt_q != mask_q
      |=> (beat_q.col[2:0] & mask_q) == (($past(beat_q.col[2:0]) + 3'h1) & mask_q))
    else $error("sequential column order wrong");

  chk_burst_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == SEQ_FIXED && cnt_q == mask_q && !start_in |=> !beat_q.valid)
    else $error("fixed burst ran past its length");

  chk_page_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_q == SEQ_PAGE && !start_in && !stop_in
      |=> beat_q.valid && beat_q.col == $past(beat_q.col) + COL_STEP)
    else $error("page burst did not step or wrap");

endmodule : smc_burst_seq

// ==== smc_mode_cfg.sv ====
// smc_mode_cfg.sv: mode and extended mode configuration with burst column ordering
`timescale 1ns/10ps
module smc_mode_cfg
  import smc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input smc_cmd_s cmd_in,
  input wire logic dpd_active_in,
  input wire logic [3:0] temp_rate_in,
  output smc_mode_s mode_cfg_out,
  output smc_ext_s ext_cfg_out,
  output logic [3:0] burst_locations_out,
  output logic [1:0] read_latency_cycles_out,
  output logic cfg_reserved_out,
  output smc_beat_s access_beat_out,
  output smc_beat_s rd_data_beat_out,
  output logic dq_drive_out,
  output logic [3:0] refresh_bank_mask_out,
  output logic [1:0] refresh_row_part_out,
  output logic [6:0] drive_ohms_out,
  output logic [3:0] self_refresh_rate_out
);

  // ==========================================================================
  // declarations
  smc_mode_s mode_q;
  smc_ext_s ext_q;
  logic [ADDR_W-EXT_W-1:0] ext_hi_q;
  logic cmd_sel;
  logic load_cmd;
  logic base_load;
  logic ext_load;
  logic rd_cmd;
  logic wr_cmd;
  logic term_cmd;
  logic lat3_cfg;
  logic [2:0] seq_span;
  logic [COL_W-1:0] start_col;
  logic [MODE_W-1:0] mode_field;
  logic [EXT_W-1:0] ext_field;
  smc_beat_s seq_beat;
  smc_beat_s rd_pipe;
  smc_beat_s stage_q;
  smc_beat_s rd_beat_q;
  logic [3:0] rate1_q;
  logic [3:0] rate2_q;
  logic [3:0] locations_q;
  logic [1:0] latency_q;
  logic reserved_q;
  logic mode_bad;
  logic ext_bad;
  logic [3:0] bank_mask_q;
  logic [1:0] row_part_q;
  logic [6:0] ohms_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ==========================================================================
  // command decode, sampled on the rising edge half a cycle after the controller drives it
  assign cmd_sel = !cmd_in.cs_n && !dpd_active_in;
  assign load_cmd = cmd_sel && !cmd_in.ras_n && !cmd_in.cas_n && !cmd_in.we_n;
  assign base_load = load_cmd && {cmd_in.bank_sel_high, cmd_in.bank_sel_low} == BANK_BASE;
  assign ext_load = load_cmd && {cmd_in.bank_sel_high, cmd_in.bank_sel_low} == BANK_EXT;
  assign rd_cmd = cmd_sel && cmd_in.ras_n && !cmd_in.cas_n && cmd_in.we_n;
  assign wr_cmd = cmd_sel && cmd_in.ras_n && !cmd_in.cas_n && !cmd_in.we_n;
  assign term_cmd = cmd_sel && cmd_in.ras_n && cmd_in.cas_n && !cmd_in.we_n;
  assign start_col = cmd_in.addr[COL_W-1:0];
  assign mode_field = cmd_in.addr[MODE_W-1:0];
  assign ext_field = cmd_in.addr[EXT_W-1:0];

  // ==========================================================================
  // base register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      mode_q <= MODE_RESET;
    else if (base_load)
      mode_q <= smc_mode_s'(mode_field);
  end

  // ==========================================================================
  // extended register; only a load changes it, deep power-down never does
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ext_q <= EXT_RESET;
      ext_hi_q <= '0;
    end
    else if (ext_load)
    begin
      ext_q <= smc_ext_s'(ext_field);
      ext_hi_q <= cmd_in.addr[ADDR_W-1:EXT_W];
    end
  end

  assign mode_cfg_out = mode_q;
  assign ext_cfg_out = ext_q;

  // ==========================================================================
  // reserved settings: the block keeps running in a defined fallback
  always_comb
  begin
    mode_bad = 1'b0;
    if (!(mode_q.burst_span inside {SPAN_1, SPAN_2, SPAN_4, SPAN_8, SPAN_PAGE}))
      mode_bad = 1'b1;
    if (!(mode_q.latency inside {LAT_2, LAT_3}))
      mode_bad = 1'b1;
    if ({mode_q.op_mode_high_bit, mode_q.op_mode_low_bit} != OPMODE_NORMAL)
      mode_bad = 1'b1;
    if (mode_q.burst_span == SPAN_PAGE && mode_q.burst_order_select)
      mode_bad = 1'b1;
  end

  always_comb
  begin
    ext_bad = (ext_hi_q != '0);
    if (!(ext_q.partial_refresh_select inside
          {PARTIAL_REFRESH_SELECT_FULL, PARTIAL_REFRESH_SELECT_HALF, PARTIAL_REFRESH_SELECT_QUARTER, PARTIAL_REFRESH_SELECT_EIGHTH, PARTIAL_REFRESH_SELECT_SIXTEENTH}))
      ext_bad = 1'b1;
  end

  // ==========================================================================
  // decoded base settings
  assign lat3_cfg = (mode_q.latency != LAT_2);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      locations_q <= 4'h1;
      latency_q <= 2'h3;
      reserved_q <= 1'b0;
    end
    else
    begin
      case (mode_q.burst_span)
        SPAN_2: locations_q <= 4'h2;
        SPAN_4: locations_q <= 4'h4;
        SPAN_8: locations_q <= 4'h8;
        SPAN_PAGE: locations_q <= 4'h0;
        default: locations_q <= 4'h1;
      endcase
      latency_q <= lat3_cfg ? 2'h3 : 2'h2;
      reserved_q <= mode_bad || ext_bad;
    end
  end

  assign burst_locations_out = locations_q;
  assign read_latency_cycles_out = latency_q;
  assign cfg_reserved_out = reserved_q;

  // ==========================================================================
  // column sequencer; partial refresh has no say over these accesses
  assign seq_span = (wr_cmd && mode_q.single_write_select) ? SPAN_1 : mode_q.burst_span;

  smc_burst_seq u_seq (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(rd_cmd || wr_cmd),
    .stop_in(term_cmd),
    .rd_in(rd_cmd),
    .start_col_in(start_col),
    .span_in(seq_span),
    .order_in(mode_q.burst_order_select),
    .beat_out(seq_beat)
  );

  assign access_beat_out = seq_beat;

  // ==========================================================================
  // read latency pipeline: beat 0 leaves the sequencer at edge n,
  // so m-1 more edges put the drive at edge n+m-1
  always_comb
  begin
    rd_pipe = seq_beat;
    rd_pipe.valid = seq_beat.valid && seq_beat.rd;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage_q <= '0;
      rd_beat_q <= '0;
    end
    else
    begin
      stage_q <= rd_pipe;
      rd_beat_q <= lat3_cfg ? stage_q : rd_pipe;
    end
  end

  assign rd_data_beat_out = rd_beat_q;
  assign dq_drive_out = rd_beat_q.valid;

  // ==========================================================================
  // refresh rate from the sensor domain; temperature bits play no part
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rate1_q <= RATE_RESET;
      rate2_q <= RATE_RESET;
    end
    else
    begin
      rate1_q <= temp_rate_in;
      rate2_q <= rate1_q;
    end
  end

  assign self_refresh_rate_out = rate2_q;

  // ==========================================================================
  // partial refresh coverage and output drive
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bank_mask_q <= BANKS_ALL;
      row_part_q <= ROWS_WHOLE;
      ohms_q <= OHM_25;
    end
    else
    begin
      case (ext_q.partial_refresh_select)
        PARTIAL_REFRESH_SELECT_HALF:
        begin
          bank_mask_q <= BANKS_LOW2;
          row_part_q <= ROWS_WHOLE;
        end
        PARTIAL_REFRESH_SELECT_QUARTER:
        begin
          bank_mask_q <= BANKS_ZERO;
          row_part_q <= ROWS_WHOLE;
        end
        PARTIAL_REFRESH_SELECT_EIGHTH:
        begin
          bank_mask_q <= BANKS_ZERO;
          row_part_q <= ROWS_HALF;
        end
        PARTIAL_REFRESH_SELECT_SIXTEENTH:
        begin
          bank_mask_q <= BANKS_ZERO;
          row_part_q <= ROWS_QUARTER;
        end
        default:
        begin
          bank_mask_q <= BANKS_ALL;
          row_part_q <= ROWS_WHOLE;
        end
      endcase
      case (ext_q.output_drive_select)
        DS_THREEQ: ohms_q <= OHM_37;
        DS_HALF: ohms_q <= OHM_55;
        DS_QUARTER: ohms_q <= OHM_80;
        default: ohms_q <= OHM_25;
      endcase
    end
  end

  assign refresh_bank_mask_out = bank_mask_q;
  assign refresh_row_part_out = row_part_q;
  assign drive_ohms_out = ohms_q;

  // ==========================================================================
  // checks
  sequence s_rd_cl2;
    rd_cmd && !lat3_cfg && !base_load;
  endsequence

  sequence s_rd_cl3;
    rd_cmd && lat3_cfg;
  endsequence

  sequence s_single_wr;
    wr_cmd && mode_q.single_write_select ##1 !(rd_cmd || wr_cmd);
  endsequence

  chk_mode_load: assert property (base_load |=> mode_q == $past(mode_field))
    else $error("base register did not take the load");

  chk_ext_load: assert property (ext_load |=> ext_q == $past(ext_field))
    else $error("extended register did not take the load");

  chk_ext_dpd: assert property (dpd_active_in |=> $stable(ext_q))
    else $error("extended register changed in deep power-down");

  chk_cl2_drive: assert property (s_rd_cl2 ##1 !base_load |-> ##1
    dq_drive_out && rd_data_beat_out.col == $past(start_col, 2))
    else $error("latency two read data not on time");

  chk_cl3_drive: assert property (s_rd_cl3 ##1 !base_load |-> ##2
    dq_drive_out && rd_data_beat_out.col == $past(start_col, 3))
    else $error("latency three read data not on time");

  chk_write_single: assert property (s_single_wr |=> !access_beat_out.valid)
    else $error("write ran longer than one location");

  chk_temp_comp_refresh_bits_ignored: assert property (self_refresh_rate_out == $past(temp_rate_in, 2))
    else $error("refresh rate not following the sensor");

  chk_partial_refresh_select_half: assert property (
    ext_q.partial_refresh_select == PARTIAL_REFRESH_SELECT_HALF |=> refresh_bank_mask_out == BANKS_LOW2)
    else $error("half array refresh coverage wrong");

  chk_drive_ohms: assert property (
    ext_q.output_drive_select == DS_THREEQ |=> drive_ohms_out == OHM_37)
    else $error("three quarter drive impedance wrong");

endmodule : smc_mode_cfg

// ==== smc_ctrl_model.sv ====
// smc_ctrl_model.sv: controller model driving the command bus
`timescale 1ns/10ps
module smc_ctrl_model
  import smc_pkg::*;
(
  input wire logic clk_in,
  output smc_cmd_s cmd_out
);
  // ==========================================================================
  // one command per call, set at a falling edge and held for one cycle
  initial cmd_out = 16'hFFFF;

  task automatic drive(input logic [2:0] rcw, input logic [1:0] bank, input logic [9:0] addr);
    cmd_out = {1'b0, rcw, bank, addr};
    @(negedge clk_in);
    // deselected lines do not keep their last value
    cmd_out = {1'b1, ~cmd_out[14:0]};
  endtask : drive

  task automatic load_base(input smc_mode_s m);
    drive(3'h0, BANK_BASE, {m.single_write_select, 2'h0, m[6:0]});
  endtask : load_base

  task automatic load_ext(input smc_ext_s e);
    drive(3'h0, BANK_EXT, {3'h0, e});
  endtask : load_ext

  task automatic access(input logic rd, input logic [8:0] col);
    drive(rd ? 3'h5 : 3'h4, 2'h0, {1'b0, col});
  endtask : access

  task automatic terminate();
    drive(3'h6, 2'h0, 10'h000);
  endtask : terminate
endmodule : smc_ctrl_model

// ==== smc_mode_cfg_tb.sv ====
// smc_mode_cfg_tb.sv: self-checking testbench for the mode configuration block
`timescale 1ns/10ps
module smc_mode_cfg_tb;
  import smc_pkg::*;
  localparam logic [2:0] PARTIAL_REFRESH_SELECT_C [5] = '{PARTIAL_REFRESH_SELECT_FULL, PARTIAL_REFRESH_SELECT_HALF, PARTIAL_REFRESH_SELECT_QUARTER, PARTIAL_REFRESH_SELECT_EIGHTH,
    PARTIAL_REFRESH_SELECT_SIXTEENTH};
  localparam logic [3:0] MASK_C [5] = '{BANKS_ALL, BANKS_LOW2, BANKS_ZERO, BANKS_ZERO, BANKS_ZERO};
  localparam logic [1:0] ROW_C [5] = '{ROWS_WHOLE, ROWS_WHOLE, ROWS_WHOLE, ROWS_HALF, ROWS_QUARTER};
  localparam logic [6:0] OHM_C [4] = '{OHM_25, OHM_55, OHM_80, OHM_37};
  logic clk_in;
  logic rst_n_in;
  smc_cmd_s cmd_in;
  logic dpd_active_in;
  logic [3:0] temp_rate_in;
  smc_mode_s mode_cfg_out;
  smc_ext_s ext_cfg_out;
  logic [3:0] burst_locations_out;
  logic [1:0] read_latency_cycles_out;
  logic cfg_reserved_out;
  smc_beat_s access_beat_out;
  smc_beat_s rd_data_beat_out;
  logic dq_drive_out;
  logic [3:0] refresh_bank_mask_out;
  logic [1:0] refresh_row_part_out;
  logic [6:0] drive_ohms_out;
  logic [3:0] self_refresh_rate_out;
  int n_fail;
  int checks;
  logic [31:0] lfsr_q;
  smc_mode_s md;
  smc_ext_s ex;
  logic [31:0] r;

  smc_ctrl_model ctrl (.clk_in(clk_in), .cmd_out(cmd_in));
  smc_mode_cfg uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
    .dpd_active_in(dpd_active_in), .temp_rate_in(temp_rate_in), .mode_cfg_out(mode_cfg_out),
    .ext_cfg_out(ext_cfg_out), .burst_locations_out(burst_locations_out),
    .read_latency_cycles_out(read_latency_cycles_out), .cfg_reserved_out(cfg_reserved_out),
    .access_beat_out(access_beat_out), .rd_data_beat_out(rd_data_beat_out),
    .dq_drive_out(dq_drive_out), .refresh_bank_mask_out(refresh_bank_mask_out),
    .refresh_row_part_out(refresh_row_part_out), .drive_ohms_out(drive_ohms_out),
    .self_refresh_rate_out(self_refresh_rate_out));

  // ==========================================================================
  // clock and watchdog
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    end_sim();
  end

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  // n = 0 means a full page
  function automatic logic [8:0] exp_col(input logic [8:0] s, input int k, input int n,
    input logic ord);
    logic [8:0] mask;
    mask = (n == 0) ? 9'h1FF : 9'(n - 1);
    return (s & ~mask) | (mask & ((ord && n != 0) ? s ^ 9'(k) : s + 9'(k)));
  endfunction : exp_col

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic burst(input logic rd, input logic [8:0] c, input int n, input int m,
    input logic ord, input int beats);
    int k;
    logic v;
    ctrl.access(rd, c);
    for (int j = 1; j <= beats + m + 1; j++)
    begin
      k = j - m;
      v = rd && k >= 0 && k < beats;
      chk("access valid", 16'(j <= beats), 16'(access_beat_out.valid));
      if (j <= beats)
        chk("access col", 16'({rd, exp_col(c, j - 1, n, ord)}), 16'(access_beat_out[9:0]));
      chk("read valid", 16'(v), 16'(rd_data_beat_out.valid));
      chk("dq drive", 16'(v), 16'(dq_drive_out));
      if (v)
        chk("read col", 16'(exp_col(c, k, n, ord)), 16'(rd_data_beat_out.col));
      @(negedge clk_in);
    end
  endtask : burst

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // main sequence
  initial
  begin
    n_fail = 0;
    checks = 0;
    lfsr_q = 32'hE5748EF4;
    rst_n_in = 1'b0;
    dpd_active_in = 1'b0;
    temp_rate_in = 4'h0;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    chk("mode reset", 16'(MODE_RESET), 16'(mode_cfg_out));
    chk("ext reset", 16'(EXT_RESET), 16'(ext_cfg_out));
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      ex = {2'(i), 2'(rnd()), PARTIAL_REFRESH_SELECT_C[i]};
      temp_rate_in = 4'(rnd());
      ctrl.load_ext(ex);
      repeat (2) @(negedge clk_in);
      chk("ext", 16'(ex), 16'(ext_cfg_out));
      chk("bank mask", 16'(MASK_C[i]), 16'(refresh_bank_mask_out));
      chk("row part", 16'(ROW_C[i]), 16'(refresh_row_part_out));
      chk("ohms", 16'(OHM_C[i % 4]), 16'(drive_ohms_out));
      chk("rate", 16'(temp_rate_in), 16'(self_refresh_rate_out));
    end
    dpd_active_in = 1'b1;
    ctrl.load_ext(~ex);
    dpd_active_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("ext kept", 16'(ex), 16'(ext_cfg_out));
    $display("test extended done");
    for (int i = 0; i < 30; i++)
    begin
      r = rnd();
      md = {r[3], 2'h0, r[2] ? LAT_3 : LAT_2, r[4], 1'b0, r[1:0]};
      ctrl.load_base(md);
      repeat (2) @(negedge clk_in);
      chk("mode", 16'(md), 16'(mode_cfg_out));
      chk("locations", 16'(1 << r[1:0]), 16'(burst_locations_out));
      chk("latency", 16'(r[2] ? 3 : 2), 16'(read_latency_cycles_out));
      chk("reserved", 16'h0000, 16'(cfg_reserved_out));
      if (r[5])
      begin
        ctrl.access(1'b0, 9'(rnd()));
        // let an edge pass so the command bus is not assigned twice in one step
        @(negedge clk_in);
      end
      burst(r[6], 9'(rnd()), 1 << r[1:0], r[2] ? 3 : 2, r[4],
        (r[6] || !r[3]) ? 1 << r[1:0] : 1);
    end
    $display("test bursts done");
    md = {1'b0, 2'h0, LAT_2, 1'b1, SPAN_PAGE};
    ctrl.load_base(md);
    repeat (2) @(negedge clk_in);
    chk("page locations", 16'h0000, 16'(burst_locations_out));
    chk("page reserved", 16'h0001, 16'(cfg_reserved_out));
    ctrl.access(1'b1, 9'h1FD);
    for (int j = 0; j < 5; j++)
    begin
      chk("page col", 16'(exp_col(9'h1FD, j, 0, 1'b1)), 16'(access_beat_out.col));
      if (j < 4)
        @(negedge clk_in);
    end
    ctrl.terminate();
    chk("page stop", 16'h0000, 16'(access_beat_out.valid));
    repeat (4) @(negedge clk_in);
    chk("page read stop", 16'h0000, 16'(rd_data_beat_out.valid));
    $display("test page done");
    end_sim();
  end
endmodule : smc_mode_cfg_tb
